// ===== rtl/rshp_pkg.sv
// Shared constants for the request sideband hint, sequence and parity block.
// Assumes a 256-bit request stream with a 62-bit sideband in one clock domain.
package rshp_pkg;
    localparam int DATA_W = 256;
    localparam int SB_W = 62;
    localparam int NBYTES = DATA_W / 8;
    localparam int SEQ_W = 6;
    localparam int ST_IDX_W = 4;
    localparam int ST_ENTRIES = 16;
    localparam int PRESENT_BIT = 12;
    localparam int PH_LO = 13;
    localparam int INDIRECT_BIT = 15;
    localparam int ST_LO = 16;
    localparam int SEQ_LO_LO = 24;
    localparam int PAR_LO = 28;
    localparam int SEQ_HI_LO = 60;
    // Width selector: 0 = 64-bit, 1 = 128-bit, 2 = 256-bit data
    localparam logic [1:0] WIDTH_64 = 2'h0;
    localparam logic [1:0] WIDTH_128 = 2'h1;
    localparam logic [1:0] WIDTH_256 = 2'h2;
    localparam int CHK_BYTES_64 = 8;
    localparam int CHK_BYTES_128 = 16;
    // Cycles from capture until the request passes the completion merge point
    localparam int SEQ_PIPE_CYCLES = 3;
    localparam logic [1:0] SEQ_PIPE_MAX = 2'h2;
endpackage

// ===== rtl/rshp_if.sv
// Request stream between user logic and the device end.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface rshp_if;
    logic [255:0] request_stream_payload;
    logic [61:0] request_stream_sideband;
    logic request_stream_valid;
    logic request_stream_ready;
    modport device (
        input request_stream_payload, request_stream_sideband,
        input request_stream_valid,
        output request_stream_ready
    );
    modport user (
        output request_stream_payload, request_stream_sideband,
        output request_stream_valid,
        input request_stream_ready
    );
endinterface
`default_nettype wire

// ===== rtl/rshp_user.sv
// User-side end: drives one-beat requests with sideband fields and parity.
// Assumes the device end holds ready high whenever it can accept.
`timescale 1ns/1ps
`default_nettype none
module rshp_user (
    input wire logic clock,
    input wire logic rst,
    rshp_if.user link,
    input wire logic send,
    input wire logic [255:0] send_payload,
    input wire logic hint_present,
    input wire logic [1:0] hint_type,
    input wire logic indirect_tag,
    input wire logic [7:0] steer_value_field,
    input wire logic [5:0] seq_in,
    input wire logic parity_on,
    output logic busy
);
    import rshp_pkg::*;
    logic valid_q, valid_d;
    logic [255:0] data_q, data_d;
    logic [61:0] sb_q, sb_d;
    logic [31:0] par;

    // Odd parity per byte
    for (genvar i = 0; i < NBYTES; i++) begin : g_par
        assign par[i] = ~^send_payload[i*8 +: 8];
    end

    always_comb begin
        valid_d = valid_q;
        data_d = data_q;
        sb_d = sb_q;
        if (valid_q && link.request_stream_ready) begin
            valid_d = 1'b0;
        end
        if (send && (!valid_q || link.request_stream_ready)) begin
            valid_d = 1'b1;
            data_d = send_payload;
            sb_d = '0;
            sb_d[PRESENT_BIT] = hint_present;
            // Hint fields go out as given, even with no hint
            sb_d[PH_LO +: 2] = hint_type;
            sb_d[INDIRECT_BIT] = indirect_tag;
            sb_d[ST_LO +: 8] = steer_value_field;
            sb_d[SEQ_LO_LO +: 4] = seq_in[3:0];
            sb_d[SEQ_HI_LO +: 2] = seq_in[5:4];
            sb_d[PAR_LO +: 32] = parity_on ? par : 32'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            valid_q <= 1'b0;
            data_q <= '0;
            sb_q <= '0;
        end else begin
            valid_q <= valid_d;
            data_q <= data_d;
            sb_q <= sb_d;
        end
    end

    assign link.request_stream_valid = valid_q;
    assign link.request_stream_payload = data_q;
    assign link.request_stream_sideband = sb_q;
    assign busy = valid_q && !link.request_stream_ready;
endmodule // rshp_user
`default_nettype wire

// ===== rtl/rshp_device.sv
// Device end: captures sideband fields, resolves steering tags, echoes
// sequence numbers and checks per-byte odd parity of request data.
// Assumes single-beat packets and a steering table loaded on a plain port.
// Assumes width_sel and parity_enable stay static while requests flow.
// What this block does
// - User drives hint-present flag at bit 12.
// - Hint type bits 14:13 go into PH.
// - Indirect bit set: tag looked up in table.
// - Indirect bit clear: tag passed through unchanged.
// - User supplies 8-bit steering tag, bits 23:16.
// - Hint fields ignored when hint flag clear.
// - Fields captured on first beat, valid and ready.
// - Sequence number bits 27:24 plus 61:60.
// - Sequence echoed once past completion overtaking point.
// - User may tie sequence number to zero.
// - User drives odd parity per data byte.
// - Check 16 bits at 128, 8 at 64.
// - Parity mismatch discards packet, flags internal error.
// - Internal error stays until reset.
// - User may zero parity when checking off.
`timescale 1ns/1ps
`default_nettype none
module rshp_device (
    input wire logic clock,
    input wire logic rst,
    rshp_if.device link,
    input wire logic parity_enable,
    input wire logic [1:0] width_sel,
    input wire logic table_we,
    input wire logic [3:0] table_addr,
    input wire logic [7:0] table_data,
    output logic req_out_valid,
    output logic [255:0] req_out_payload,
    output logic req_out_hint,
    output logic [1:0] req_out_ph,
    output logic [7:0] req_out_steer_tag,
    output logic progress_tag_valid,
    output logic [5:0] progress_tag_out,
    output logic internal_error,
    output logic parity_error_pulse
);
    import rshp_pkg::*;
    logic [7:0] steer_table [ST_ENTRIES];
    logic [7:0] table_d [ST_ENTRIES];

    logic [61:0] sb;
    logic beat;
    logic take;

    logic [31:0] byte_ok;
    logic [31:0] chk_mask;
    int chk_bytes;
    logic par_bad;

    logic err_q, err_d;
    logic ready_q, ready_d;
    logic pe_q, pe_d;

    logic ov_q, ov_d;
    logic [255:0] od_q, od_d;
    logic oh_q, oh_d;
    logic [1:0] ph_q, ph_d;
    logic [7:0] st_q, st_d;

    logic [SEQ_PIPE_CYCLES-1:0] sv_q, sv_d;
    logic [5:0] sq_q [SEQ_PIPE_CYCLES];
    logic [5:0] sq_d [SEQ_PIPE_CYCLES];

    assign sb = link.request_stream_sideband;
    assign beat = link.request_stream_valid && ready_q;
    // A packet is forwarded only if it passed the check
    assign take = beat && !err_q && !par_bad;

    // Unused width code checks the whole bus
    always_comb begin
        chk_bytes = NBYTES;
        unique case (width_sel)
            WIDTH_64: chk_bytes = CHK_BYTES_64;
            WIDTH_128: chk_bytes = CHK_BYTES_128;
            WIDTH_256: chk_bytes = NBYTES;
            default: chk_bytes = NBYTES;
        endcase
    end

    // Byte passes when byte and its bit hold an odd count of ones
    for (genvar i = 0; i < NBYTES; i++) begin : g_chk
        assign byte_ok[i] = ^{link.request_stream_payload[i*8 +: 8],
                              sb[PAR_LO + i]};
        assign chk_mask[i] = (i < chk_bytes);
    end

    assign par_bad = parity_enable && |(chk_mask & ~byte_ok);

    // Entry written now is readable from the next cycle
    always_comb begin
        table_d = steer_table;
        if (table_we) begin
            table_d[table_addr] = table_data;
        end
    end

    always_ff @(posedge clock) begin
        steer_table <= table_d;
    end

    // Parity error closes the port until reset
    always_comb begin
        err_d = err_q;
        pe_d = 1'b0;
        ready_d = !err_q;
        if (beat && !err_q && par_bad) begin
            err_d = 1'b1;
            pe_d = 1'b1;
            ready_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            err_q <= 1'b0;
            ready_q <= 1'b0;
            pe_q <= 1'b0;
        end else begin
            err_q <= err_d;
            ready_q <= ready_d;
            pe_q <= pe_d;
        end
    end

    // Hint fields are trusted only with the hint flag set
    always_comb begin
        ov_d = 1'b0;
        od_d = od_q;
        oh_d = oh_q;
        ph_d = ph_q;
        st_d = st_q;
        if (take) begin
            ov_d = 1'b1;
            od_d = link.request_stream_payload;
            oh_d = sb[PRESENT_BIT];
            ph_d = 2'h0;
            st_d = 8'h0;
            if (sb[PRESENT_BIT]) begin
                ph_d = sb[PH_LO +: 2];
                if (sb[INDIRECT_BIT]) begin
                    st_d = steer_table[sb[ST_LO +: ST_IDX_W]];
                end else begin
                    st_d = sb[ST_LO +: 8];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ov_q <= 1'b0;
            od_q <= '0;
            oh_q <= 1'b0;
            ph_q <= 2'h0;
            st_q <= 8'h0;
        end else begin
            ov_q <= ov_d;
            od_q <= od_d;
            oh_q <= oh_d;
            ph_q <= ph_d;
            st_q <= st_d;
        end
    end

    // Sequence number walks to the no-overtake point
    always_comb begin
        sv_d = {sv_q[SEQ_PIPE_CYCLES-2:0], take};
        sq_d[0] = sq_q[0];
        if (take) begin
            sq_d[0] = {sb[SEQ_HI_LO +: 2], sb[SEQ_LO_LO +: 4]};
        end
        for (int k = 1; k < SEQ_PIPE_CYCLES; k++) begin
            sq_d[k] = sq_q[k-1];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sv_q <= '0;
            for (int k = 0; k < SEQ_PIPE_CYCLES; k++) begin
                sq_q[k] <= 6'h0;
            end
        end else begin
            sv_q <= sv_d;
            for (int k = 0; k < SEQ_PIPE_CYCLES; k++) begin
                sq_q[k] <= sq_d[k];
            end
        end
    end

    // Every output below is a register
    assign link.request_stream_ready = ready_q;
    assign req_out_valid = ov_q;
    assign req_out_payload = od_q;
    assign req_out_hint = oh_q;
    assign req_out_ph = ph_q;
    assign req_out_steer_tag = st_q;
    assign progress_tag_valid = sv_q[SEQ_PIPE_MAX];
    assign progress_tag_out = sq_q[SEQ_PIPE_MAX];
    assign internal_error = err_q;
    assign parity_error_pulse = pe_q;
endmodule // rshp_device
`default_nettype wire

// ===== bench/rshp_assertions.sv
// Concurrent checks on the request stream between the two ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rshp_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic [255:0] request_stream_payload,
    input wire logic [61:0] request_stream_sideband,
    input wire logic request_stream_valid,
    input wire logic request_stream_ready
);
    wire logic v = request_stream_valid;
    wire logic r = request_stream_ready;
    wire logic acc = v && r;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_ready_in_reset: assert property ($fell(rst) |-> !r)
        else $error("ready high during reset");
    a_ready_after_rst: assert property ($fell(rst) |=> r)
        else $error("ready not raised after reset");
    a_valid_in_reset: assert property ($fell(rst) |-> !v)
        else $error("valid high during reset");
    a_stall_fields: assert property (
        v && !r |=> v && $stable(request_stream_sideband))
        else $error("sideband moved while stalled");
    a_stall_data: assert property (
        v && !r |=> $stable(request_stream_payload))
        else $error("payload moved while stalled");
    a_drop_after_beat: assert property ($fell(r) |-> $past(acc))
        else $error("ready fell without a taken beat");
    a_error_sticky: assert property ($fell(r) |-> !r [*8])
        else $error("ready came back before reset");
    c_back_to_back: cover property (acc ##1 acc);
    c_ready_drop: cover property ($fell(r));
    c_stalled: cover property (v && !r);
endmodule // rshp_assertions
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench joining the user end to the device end.
// Assumes the package and the interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rshp_pkg::*;
    logic clock = 0, rst = 1, send = 0, hp = 0, ind = 0, pon = 1;
    logic pen = 1, we = 0, ov, oh, ptv, ierr, perr, busy;
    logic [1:0] ht = 0, wsel = WIDTH_256, oph;
    logic [7:0] tag = 0, td = 0, otag;
    logic [3:0] ta = 0;
    logic [5:0] seq = 0, pto;
    logic [255:0] pay = 0, opay;
    logic [1:0] ws [3] = '{WIDTH_64, WIDTH_128, WIDTH_256};
    int num_errors = 0, checks_done = 0, cyc = 0;
    rshp_if link ();
    always #4 clock = ~clock;
    rshp_user u_rshp_user (.clock(clock), .rst(rst), .link(link),
        .send(send), .send_payload(pay), .hint_present(hp),
        .hint_type(ht), .indirect_tag(ind), .steer_value_field(tag),
        .seq_in(seq), .parity_on(pon), .busy(busy));
    rshp_device u_rshp_device (.clock(clock), .rst(rst), .link(link),
        .parity_enable(pen), .width_sel(wsel), .table_we(we),
        .table_addr(ta), .table_data(td), .req_out_valid(ov),
        .req_out_payload(opay), .req_out_hint(oh), .req_out_ph(oph),
        .req_out_steer_tag(otag), .progress_tag_valid(ptv),
        .progress_tag_out(pto), .internal_error(ierr),
        .parity_error_pulse(perr));
    rshp_assertions u_rshp_assertions (.clock(clock), .rst(rst),
        .request_stream_payload(link.request_stream_payload),
        .request_stream_sideband(link.request_stream_sideband),
        .request_stream_valid(link.request_stream_valid),
        .request_stream_ready(link.request_stream_ready));
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [255:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input int n);
        @(negedge clock);
        rst = 1;
        repeat (n) @(negedge clock);
        rst = 0;
        repeat (2) @(negedge clock);
    endtask
    // f is {hint, type, indirect, tag}; returns just after the taken edge
    task automatic put(input logic [11:0] f, input logic [255:0] p);
        int n = 0;
        @(negedge clock);
        {hp, ht, ind, tag, pay, send} = {f, p, 1'b1};
        @(negedge clock);
        send = 0;
        while (!(link.request_stream_valid && link.request_stream_ready)
                && n < 20) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
    endtask
    task automatic t_hint();
        seq = 6'h2d;
        put(12'hea5, {8{32'h0102_0407}});
        chk(ov, 1);
        chk(busy, 0);
        chk(opay, {8{32'h0102_0407}});
        chk({oh, oph}, 3'h7);
        chk(otag, 8'ha5);
        repeat (2) @(negedge clock);
        chk({ov, ptv, pto}, 8'h6d);
        seq = 0;
        put(12'h7ff, 0);
        chk({ov, oh, oph, otag}, 12'h800);
        repeat (2) @(negedge clock);
        chk({ov, ptv, pto}, 8'h40);
    endtask
    task automatic t_table();
        @(negedge clock);
        {we, ta, td} = {1'b1, 4'h7, 8'h3c};
        @(negedge clock);
        we = 0;
        put(12'hbf7, 0);
        chk({ov, oph, otag}, 11'h53c);
    endtask
    task automatic t_parity();
        pon = 0;
        for (int k = 0; k < 3; k++) begin
            {wsel, pen} = {ws[k], k != 2};
            // Bytes above the checked range carry bad parity; the 256-bit pass runs with checking off
            put(0, (k == 0) ? {8{8'h01}} : {16{8'h01}});
            chk({ov, perr, ierr}, 3'h4);
        end
        pen = 1;
        put(0, {16{8'h01}});
        chk({ov, perr, ierr}, 3'h3);
        chk(link.request_stream_ready, 0);
        repeat (10) @(negedge clock);
        chk({ierr, link.request_stream_ready, perr}, 3'h4);
        put(12'h800, 0);
        chk({busy, ov, link.request_stream_valid}, 3'h5);
        pon = 1;
        do_reset(2);
        chk({ierr, busy}, 2'h0);
        put(0, {8{32'h8040_2010}});
        chk({ov, perr}, 2'h2);
        {wsel, pon} = {WIDTH_64, 1'b0};
        put(0, {7{8'h01}});
        chk({ov, perr, ierr}, 3'h3);
    endtask
    initial begin
        do_reset(16);
        t_hint();
        t_table();
        t_parity();
        summarize();
    end
endmodule // tb
`default_nettype wire
